/* File: core/asfl_chan_flags.sv */
// per-channel completion and overrun flags
`timescale 1ns/1ps
module asfl_chan_flags (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // events
  input  wire logic end_ok,
  input  wire logic rd_own,
  input  wire logic rd_last_own,
  input  wire logic rd_status,
  // flags
  output logic      eoc,
  output logic      ovr
);

  logic next_eoc;
  logic next_ovr;

  // set wins over any read that lands in the same cycle
  assign next_eoc = end_ok ? 1'b1 :
                    (rd_own | rd_last_own) ? 1'b0 :
                    eoc;

  // overrun needs the old completion flag, so a cleared flag
  // lets a status read win even against a fresh end
  assign next_ovr = (end_ok & eoc) ? 1'b1 :
                    rd_status ? 1'b0 :
                    ovr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc <= asfl_pkg::ASFL_RST_BIT;
      ovr <= asfl_pkg::ASFL_RST_BIT;
    end else begin
      eoc <= next_eoc;
      ovr <= next_ovr;
    end
  end

endmodule

/* File: core/asfl_irq.sv */
// sticky interrupt status with write-one clear and enable
`timescale 1ns/1ps
module asfl_irq #(
  parameter int N = asfl_pkg::ASFL_NIRQ
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // events and software control
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] clear_in,
  input  wire logic         en_wr,
  input  wire logic [N-1:0] en_data,
  // state
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);

  logic [N-1:0] next_status;

  // a clear meeting an event keeps the bit
  assign next_status = event_in | (status & ~clear_in);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      enable <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      if (en_wr) begin
        enable <= en_data;
      end
      irq    <= |(next_status & (en_wr ? en_data : enable));
    end
  end

endmodule

/* File: core/asfl_pkg.sv */
// constants and types of the converter status-flag logic
// Behaviour
// - data read plus busy end sets general overrun
// - disable elsewhere never masks a channel overrun
// - channel or last-data read clears completion flag
// - status read clears channel overrun despite a new end on a channel already read
// - channel disabled mid-conversion never raises completion
// - channel data read clears only own flag
// - idle sleep request waits for next conversion end
// - only last-data read clears result ready
// - one general overrun flag, status read updates
package asfl_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ASFL_NCH = 8;
  localparam int ASFL_CHW = 3;
  localparam int ASFL_DW  = 10;
  localparam int ASFL_AW  = 8;
  localparam int ASFL_NIRQ = 3;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ASFL_OFF_CTRL    = 8'h00;
  localparam logic [7:0] ASFL_OFF_MODE    = 8'h04;
  localparam logic [7:0] ASFL_OFF_CHEN    = 8'h10;
  localparam logic [7:0] ASFL_OFF_CHDIS   = 8'h14;
  localparam logic [7:0] ASFL_OFF_CHSR    = 8'h18;
  localparam logic [7:0] ASFL_OFF_STATUS  = 8'h1C;
  localparam logic [7:0] ASFL_OFF_LAST_CONVERTED_DATA_REGISTER    = 8'h20;
  localparam logic [7:0] ASFL_OFF_INT_ST  = 8'h24;
  localparam logic [7:0] ASFL_OFF_INT_CLR = 8'h28;
  localparam logic [7:0] ASFL_OFF_INT_EN  = 8'h2C;
  localparam logic [7:0] ASFL_OFF_CDR0    = 8'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ASFL_CTRL_START = 1;
  localparam int ASFL_MODE_SLEEP = 5;
  localparam int ASFL_ST_OVR_LSB = 8;
  localparam int ASFL_ST_RDY     = 16;
  localparam int ASFL_ST_GOVR    = 17;
  localparam int ASFL_LAST_CONVERTED_DATA_REGISTER_CH_LSB = 16;
  localparam int ASFL_IRQ_END    = 0;
  localparam int ASFL_IRQ_OVR    = 1;
  localparam int ASFL_IRQ_GOVR   = 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] ASFL_RST_WORD = 32'h0000_0000;
  localparam logic        ASFL_RST_BIT  = 1'b0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic                valid;
    logic [ASFL_CHW-1:0] chan;
    logic [ASFL_DW-1:0]  data;
  } asfl_conv_end_t;

  typedef enum logic [0:0] {
    ASFL_PWR_ON,
    ASFL_PWR_SLEEP
  } asfl_pwr_t;

endpackage

/* File: core/asfl_top.sv */
// converter status-flag logic with apb register slave
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module asfl_top #(
  parameter int NCH = asfl_pkg::ASFL_NCH
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [asfl_pkg::ASFL_AW-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // converter core
  input  wire asfl_pkg::asfl_conv_end_t     conv_end,
  output logic                              conv_start,
  output logic                              low_power,
  // interrupt
  output logic                              irq
);

  // ****************************************************************
  // apb handshake
  // ****************************************************************
  // one wait state so read data leaves a flip-flop
  logic access;
  logic fire;
  logic wr_fire;
  logic rd_fire;
  logic next_pready;

  assign access      = psel & penable;
  assign fire        = access & pready;
  assign wr_fire     = fire & pwrite;
  assign rd_fire     = fire & ~pwrite;
  assign next_pready = access & ~pready;

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic       hit_ctrl;
  logic       hit_mode;
  logic       hit_chen;
  logic       hit_chdis;
  logic       hit_chsr;
  logic       hit_status;
  logic       hit_last_converted_data_register;
  logic       hit_int_st;
  logic       hit_int_clr;
  logic       hit_int_en;
  logic [7:0] cdr_off;
  logic [5:0] cdr_idx;
  logic       hit_cdr;
  logic       mapped;

  assign hit_ctrl    = paddr == asfl_pkg::ASFL_OFF_CTRL;
  assign hit_mode    = paddr == asfl_pkg::ASFL_OFF_MODE;
  assign hit_chen    = paddr == asfl_pkg::ASFL_OFF_CHEN;
  assign hit_chdis   = paddr == asfl_pkg::ASFL_OFF_CHDIS;
  assign hit_chsr    = paddr == asfl_pkg::ASFL_OFF_CHSR;
  assign hit_status  = paddr == asfl_pkg::ASFL_OFF_STATUS;
  assign hit_last_converted_data_register    = paddr == asfl_pkg::ASFL_OFF_LAST_CONVERTED_DATA_REGISTER;
  assign hit_int_st  = paddr == asfl_pkg::ASFL_OFF_INT_ST;
  assign hit_int_clr = paddr == asfl_pkg::ASFL_OFF_INT_CLR;
  assign hit_int_en  = paddr == asfl_pkg::ASFL_OFF_INT_EN;
  assign cdr_off     = paddr - asfl_pkg::ASFL_OFF_CDR0;
  assign cdr_idx     = cdr_off[7:2];
  assign hit_cdr     = (paddr >= asfl_pkg::ASFL_OFF_CDR0)
                     & (paddr[1:0] == 2'h0)
                     & (int'(cdr_idx) < NCH);
  assign mapped      = hit_ctrl | hit_mode | hit_chen | hit_chdis
                     | hit_chsr | hit_status | hit_last_converted_data_register | hit_int_st
                     | hit_int_clr | hit_int_en | hit_cdr;

  // ****************************************************************
  // software-written control
  // ****************************************************************
  logic [NCH-1:0] chan_en;
  logic [NCH-1:0] dis_now;
  logic [NCH-1:0] next_chan_en;
  logic           sleep_sel;
  logic           start_wr;

  assign dis_now      = (wr_fire & hit_chdis) ? pwdata[NCH-1:0]
                                              : '0;
  assign next_chan_en = ((wr_fire & hit_chen) ? pwdata[NCH-1:0]
                                              : '0)
                      | (chan_en & ~dis_now);
  assign start_wr     = wr_fire & hit_ctrl
                      & pwdata[asfl_pkg::ASFL_CTRL_START];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_en    <= '0;
      sleep_sel  <= asfl_pkg::ASFL_RST_BIT;
      conv_start <= asfl_pkg::ASFL_RST_BIT;
    end else begin
      chan_en    <= next_chan_en;
      conv_start <= start_wr;
      if (wr_fire & hit_mode) begin
        sleep_sel <= pwdata[asfl_pkg::ASFL_MODE_SLEEP];
      end
    end
  end

  // ****************************************************************
  // conversion end qualification
  // ****************************************************************
  // a channel turned off before or at its end stores nothing
  logic [NCH-1:0] end_hit;
  logic [NCH-1:0] end_ok;
  logic           any_end;

  assign any_end = |end_ok;

  // ****************************************************************
  // register reads with side effects
  // ****************************************************************
  logic [NCH-1:0] rd_cdr;
  logic           rd_last_converted_data_register;
  logic           rd_status;

  assign rd_last_converted_data_register   = rd_fire & hit_last_converted_data_register;
  assign rd_status = rd_fire & hit_status;

  // ****************************************************************
  // last result
  // ****************************************************************
  logic [asfl_pkg::ASFL_DW-1:0]  last_data;
  logic [asfl_pkg::ASFL_CHW-1:0] last_chan;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_data <= '0;
      last_chan <= '0;
    end else if (any_end) begin
      last_data <= conv_end.data;
      last_chan <= conv_end.chan;
    end
  end

  // ****************************************************************
  // per-channel flags and results
  // ****************************************************************
  logic [NCH-1:0]               eoc;
  logic [NCH-1:0]               ovr;
  logic [asfl_pkg::ASFL_DW-1:0] chan_data [NCH];
  logic [NCH-1:0]               new_ovr;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      logic rd_last_own;

      assign end_hit[gi] = conv_end.valid
                         & (int'(conv_end.chan) == gi);
      assign end_ok[gi]  = end_hit[gi] & chan_en[gi]
                         & ~dis_now[gi];
      // own index only, never a neighbour
      assign rd_cdr[gi]  = rd_fire & hit_cdr
                         & (int'(cdr_idx) == gi);
      assign rd_last_own = rd_last_converted_data_register
                         & (int'(last_chan) == gi);
      assign new_ovr[gi] = end_ok[gi] & eoc[gi];

      asfl_chan_flags u_flags (
        .pclk        (pclk),
        .presetn     (presetn),
        .end_ok      (end_ok[gi]),
        .rd_own      (rd_cdr[gi]),
        .rd_last_own (rd_last_own),
        .rd_status   (rd_status),
        .eoc         (eoc[gi]),
        .ovr         (ovr[gi])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_data[gi] <= '0;
        end else if (end_ok[gi]) begin
          chan_data[gi] <= conv_end.data;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // global ready and general overrun
  // ****************************************************************
  logic result_ready_flag;
  logic general_overrun_flag;
  logic next_ready;
  logic next_govr;
  logic govr_event;

  // channel data reads do not touch ready
  assign next_ready = any_end ? 1'b1 :
                      rd_last_converted_data_register ? 1'b0 :
                      result_ready_flag;
  // ready still set at an end means a result was lost,
  // whatever read or disable of another channel hits the same cycle
  assign govr_event = any_end & result_ready_flag;
  assign next_govr  = govr_event ? 1'b1 :
                      rd_status ? 1'b0 :
                      general_overrun_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ready_flag    <= asfl_pkg::ASFL_RST_BIT;
      general_overrun_flag <= asfl_pkg::ASFL_RST_BIT;
    end else begin
      result_ready_flag    <= next_ready;
      general_overrun_flag <= next_govr;
    end
  end

  // ****************************************************************
  // sleep control
  // ****************************************************************
  // the switch into sleep only acts on a conversion end, so an idle
  // request waits; software starts one conversion to get there
  asfl_pkg::asfl_pwr_t pwr;
  asfl_pkg::asfl_pwr_t next_pwr;

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      asfl_pkg::ASFL_PWR_ON: begin
        if (sleep_sel & conv_end.valid) begin
          next_pwr = asfl_pkg::ASFL_PWR_SLEEP;
        end
      end
      asfl_pkg::ASFL_PWR_SLEEP: begin
        if (start_wr | ~sleep_sel) begin
          next_pwr = asfl_pkg::ASFL_PWR_ON;
        end
      end
      default: begin
        next_pwr = asfl_pkg::ASFL_PWR_ON;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr       <= asfl_pkg::ASFL_PWR_ON;
      low_power <= asfl_pkg::ASFL_RST_BIT;
    end else begin
      pwr       <= next_pwr;
      low_power <= next_pwr == asfl_pkg::ASFL_PWR_SLEEP;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [asfl_pkg::ASFL_NIRQ-1:0] irq_event;
  logic [asfl_pkg::ASFL_NIRQ-1:0] irq_clear;
  logic [asfl_pkg::ASFL_NIRQ-1:0] irq_status;
  logic [asfl_pkg::ASFL_NIRQ-1:0] irq_enable;

  assign irq_event[asfl_pkg::ASFL_IRQ_END]  = any_end;
  assign irq_event[asfl_pkg::ASFL_IRQ_OVR]  = |new_ovr;
  assign irq_event[asfl_pkg::ASFL_IRQ_GOVR] = govr_event;
  assign irq_clear = (wr_fire & hit_int_clr)
                   ? pwdata[asfl_pkg::ASFL_NIRQ-1:0] : '0;

  asfl_irq #(
    .N (asfl_pkg::ASFL_NIRQ)
  ) u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (irq_event),
    .clear_in (irq_clear),
    .en_wr    (wr_fire & hit_int_en),
    .en_data  (pwdata[asfl_pkg::ASFL_NIRQ-1:0]),
    .status   (irq_status),
    .enable   (irq_enable),
    .irq      (irq)
  );

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] status_word;
  logic [31:0] last_converted_data_register_word;
  logic [31:0] cdr_word;
  logic [31:0] rd_value;

  assign status_word = {14'h0000, general_overrun_flag,
                        result_ready_flag,
                        8'(ovr), 8'(eoc)};
  assign last_converted_data_register_word   = {13'h0000, last_chan,
                        6'h00, last_data};
  assign cdr_word    = {22'h00_0000,
                        chan_data[hit_cdr ? cdr_idx[2:0] : 3'h0]};
  assign rd_value    = hit_mode   ? (32'h0000_0001
                                     << asfl_pkg::ASFL_MODE_SLEEP)
                                    & {32{sleep_sel}} :
                       hit_chsr   ? 32'(chan_en) :
                       hit_status ? status_word :
                       hit_last_converted_data_register   ? last_converted_data_register_word :
                       hit_int_st ? 32'(irq_status) :
                       hit_int_en ? 32'(irq_enable) :
                       hit_cdr    ? cdr_word :
                       asfl_pkg::ASFL_RST_WORD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= asfl_pkg::ASFL_RST_WORD;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pready & ~mapped;
      if (next_pready & ~pwrite) begin
        prdata <= rd_value;
      end
    end
  end

endmodule

/* File: tb/asfl_chk.sv */
// port checker for the converter status-flag logic
`timescale 1ns/1ps
module asfl_chk #(
  parameter int NCH = asfl_pkg::ASFL_NCH
) (
  // clock and reset
  input wire logic                         pclk,
  input wire logic                         presetn,
  // apb slave
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [asfl_pkg::ASFL_AW-1:0] paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  // converter core and interrupt
  input wire asfl_pkg::asfl_conv_end_t     conv_end,
  input wire logic                         conv_start,
  input wire logic                         low_power,
  input wire logic                         irq
);
  // ********************
  // helpers
  // ********************
  wire logic done = psel && penable && pready;
  wire logic mapped = (paddr == 8'h00) || (paddr == 8'h04) ||
    ((paddr >= 8'h10) && (paddr < 8'(8'h30 + 4 * NCH)) &&
     (paddr[1:0] == 2'h0));
  wire logic start_wr = done && pwrite && (paddr == 8'h00) &&
    pwdata[asfl_pkg::ASFL_CTRL_START];
  wire logic mode_wr = done && pwrite && (paddr == 8'h04);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  // ********************
  // assertions
  // ********************
  AST_ONE_WAIT:
    assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_PHASE:
    assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside second access cycle");
  AST_SLVERR_UNMAP:
    assert property (done && !mapped |-> pslverr)
    else $error("unmapped access without slave error");
  AST_SLVERR_MAP:
    assert property (pslverr |-> pready && !mapped)
    else $error("slave error on mapped access");
  AST_UNMAP_ZERO:
    assert property (done && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  AST_START_PULSE:
    assert property (start_wr |=> conv_start ##1 !conv_start)
    else $error("start write without one-cycle start pulse");
  AST_START_CAUSE:
    assert property (conv_start |-> $past(start_wr))
    else $error("start pulse without start write");
  AST_SLEEP_ENTRY:
    assert property ($rose(low_power) |-> $past(conv_end.valid))
    else $error("sleep entered without a conversion end");
  // the sleep bit is registered, so a mode write wakes one cycle late
  AST_SLEEP_HOLD:
    assert property (low_power && !start_wr && !mode_wr && !$past(mode_wr)
                     |=> low_power)
    else $error("sleep left without a wake cause");
  AST_WAKE_START:
    assert property (start_wr |=> !low_power)
    else $error("start write did not wake the converter");
endmodule

bind asfl_top asfl_chk #(.NCH(NCH)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .conv_end, .conv_start, .low_power, .irq
);

/* File: tb/asfl_conv_model.sv */
// behavioural converter core producing conversion ends
`timescale 1ns/1ps
module asfl_conv_model #(
  parameter int LAT = 4
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // requests from block and bench
  input  wire logic               conv_start,
  input  wire logic               fire,
  input  wire logic               arm,
  input  wire logic               bus_hit,
  input  wire logic [2:0]         fire_ch,
  // conversion end
  output asfl_pkg::asfl_conv_end_t conv_end
);
  // ********************
  // end generation
  // ********************
  logic       pend;
  logic       tog;
  logic [7:0] cnt;
  wire logic  hit = pend || (arm && bus_hit) || (cnt == 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'h0;
      tog <= 1'h0;
      cnt <= 8'h00;
    end else begin
      pend <= fire;
      tog <= ~tog;
      cnt <= conv_start ? 8'(LAT) : (cnt != 8'h00 ? cnt - 8'h01 : cnt);
    end
  end

  // idle lines toggle so a stale value never passes for a result
  assign conv_end.valid = hit;
  assign conv_end.chan = hit ? fire_ch : {3{tog}};
  assign conv_end.data = hit ? {7'h5A, fire_ch} : {10{tog}};
endmodule

/* File: tb/asfl_top_test.sv */
// self-checking bench for the converter status-flag logic
`timescale 1ns/1ps
module asfl_top_test;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } asfl_row_t;
  // ********************
  // signals
  // ********************
  logic                     pclk, presetn, psel, penable, pwrite;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd_v;
  logic                     pready, pslverr, er_v, irq;
  logic                     conv_start, low_power, fire, arm;
  logic [2:0]               fire_ch;
  asfl_pkg::asfl_conv_end_t conv_end;
  int                       err_count, check_count;
  asfl_row_t                rows [16];

  asfl_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_end, .conv_start, .low_power, .irq
  );
  asfl_conv_model u_conv (
    .pclk, .presetn, .conv_start, .fire, .arm,
    .bus_hit(psel && penable && pready), .fire_ch, .conv_end
  );

  always #10 pclk = ~pclk;

  // ********************
  // tasks
  // ********************
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic bit_chk(input string n, input logic x, input logic g);
    chk(n, {31'h0, x}, {31'h0, g});
  endtask

  // h lets the model end a conversion in the access cycle itself
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic h,
                     input logic [2:0] c);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    arm <= h;
    fire_ch <= c;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    // pready, prdata and pslverr are taken at the completing edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd_v = prdata;
    er_v = pslverr;
    bit_chk("pready", 1'h1, pready);
    psel <= 1'h0;
    penable <= 1'h0;
    arm <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic h = 1'h0, input logic [2:0] c = 3'h0);
    apb(1'h0, a, 32'h0, h, c);
    chk($sformatf("read %h", a), x, rd_v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic h = 1'h0, input logic [2:0] c = 3'h0);
    apb(1'h1, a, d, h, c);
  endtask

  task automatic fire_end(input logic [2:0] c);
    @(posedge pclk);
    fire <= 1'h1;
    fire_ch <= c;
    @(posedge pclk);
    fire <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ********************
  // watchdog and tests
  // ********************
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    print_verdict();
  end

  initial begin
    int n;
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'h0;
    arm = 1'h0;
    fire_ch = 3'h0;
    err_count = 0;
    check_count = 0;
    rows = '{
      '{1'h0, 8'h1C, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h20, 32'h0, 32'h0, 1'h0},
      '{1'h0, 8'h18, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
      '{1'h0, 8'h2C, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h24, 32'h0, 32'h0, 1'h0},
      '{1'h0, 8'h30, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h08, 32'h0, 32'h0, 1'h1},
      '{1'h1, 8'h0C, 32'hFF, 32'h0, 1'h1}, '{1'h0, 8'h50, 32'h0, 32'h0, 1'h1},
      '{1'h1, 8'h10, 32'hFF, 32'h0, 1'h0}, '{1'h1, 8'h14, 32'h81, 32'h0, 1'h0},
      '{1'h0, 8'h18, 32'h0, 32'h7E, 1'h0}, '{1'h1, 8'h2C, 32'h7, 32'h0, 1'h0},
      '{1'h0, 8'h2C, 32'h0, 32'h7, 1'h0}, '{1'h1, 8'h10, 32'hFF, 32'h0, 1'h0}};
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, 1'h0, 3'h0);
      if (!rows[i].w) chk("row data", rows[i].x, rd_v);
      bit_chk("row error", rows[i].e, er_v);
    end
    // back-to-back ends, then channel and last-result reads
    fire_end(3'h1);
    fire_end(3'h2);
    rd(8'h1C, 32'h0003_0006);
    rd(8'h34, 32'h0000_02D1);
    rd(8'h1C, 32'h0001_0004);
    rd(8'h20, 32'h0002_02D2);
    rd(8'h1C, 32'h0);
    fire_end(3'h3);
    fire_end(3'h4);
    rd(8'h1C, 32'h0003_0018);
    rd(8'h44, 32'h0, 1'h1, 3'h3);
    rd(8'h3C, 32'h0000_02D3);
    rd(8'h1C, 32'h0003_0810, 1'h1, 3'h3);
    rd(8'h1C, 32'h0003_0018);
    // disable elsewhere while channel 4 ends with its flag set
    wr(8'h14, 32'h40, 1'h1, 3'h4);
    rd(8'h1C, 32'h0003_1018);
    rd(8'h18, 32'hBF);
    rd(8'h3C, 32'h0000_02D3, 1'h1, 3'h6);
    rd(8'h1C, 32'h0001_0010);
    rd(8'h20, 32'h0004_02D4);
    rd(8'h1C, 32'h0);
    // interrupt raise, mask and clear
    settle();
    bit_chk("irq", 1'h1, irq);
    wr(8'h2C, 32'h0);
    settle();
    bit_chk("irq", 1'h0, irq);
    wr(8'h28, 32'h7);
    rd(8'h24, 32'h0);
    fire_end(3'h1);
    rd(8'h24, 32'h1);
    wr(8'h2C, 32'h1);
    settle();
    bit_chk("irq", 1'h1, irq);
    wr(8'h28, 32'h1);
    settle();
    bit_chk("irq", 1'h0, irq);
    // sleep waits for a conversion end
    wr(8'h04, 32'h20);
    repeat (8) @(posedge pclk);
    settle();
    bit_chk("low_power", 1'h0, low_power);
    wr(8'h00, 32'h2);
    n = 0;
    while (low_power !== 1'h1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    bit_chk("low_power", 1'h1, low_power);
    // a start write wakes the converter before its next end
    wr(8'h00, 32'h2);
    settle();
    bit_chk("low_power wake", 1'h0, low_power);
    wr(8'h04, 32'h0);
    settle();
    bit_chk("low_power", 1'h0, low_power);
    // reset in mid-run clears flags and enables
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h0);
    print_verdict();
  end
endmodule
